// *** hdl/cps_pkg.sv ***
// constants shared by the configuration pin and serial load control block
package cps_pkg;

  // apb register byte offsets
  localparam logic [7:0] CPS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CPS_OFF_STATUS   = 8'h04;
  localparam logic [7:0] CPS_OFF_BIAS     = 8'h08;
  localparam logic [7:0] CPS_OFF_CFG_WORD = 8'h0C;
  localparam logic [7:0] CPS_OFF_SCAN_TDI = 8'h10;
  localparam logic [7:0] CPS_OFF_SCAN_TMS = 8'h14;
  localparam logic [7:0] CPS_OFF_SCAN_OUT = 8'h18;

  // ctrl fields
  localparam int CPS_CTRL_DONE     = 0;
  localparam int CPS_CTRL_KEEP     = 1;
  localparam int CPS_CTRL_RESTART  = 2;
  localparam int CPS_CTRL_READBACK = 3;

  // status fields
  localparam int CPS_STS_ACTIVE   = 0;
  localparam int CPS_STS_WORD     = 1;
  localparam int CPS_STS_REFUSED  = 2;
  localparam int CPS_STS_SERIAL   = 3;
  localparam int CPS_STS_MODE_LSB = 4;
  localparam int CPS_STS_HSWAP    = 7;
  localparam int CPS_STS_CNT_LSB  = 8;

  // bias field positions inside the bias register
  localparam int CPS_BIAS_IDLE_LSB  = 0;
  localparam int CPS_BIAS_HSWAP_LSB = 2;
  localparam int CPS_BIAS_TCK_LSB   = 4;
  localparam int CPS_BIAS_TDI_LSB   = 6;
  localparam int CPS_BIAS_TMS_LSB   = 8;
  localparam int CPS_BIAS_TDO_LSB   = 10;

  // bias encodings
  localparam logic [1:0] CPS_BIAS_NONE = 2'h0;
  localparam logic [1:0] CPS_BIAS_UP   = 2'h1;
  localparam logic [1:0] CPS_BIAS_DOWN = 2'h2;

  // reset values
  localparam logic [11:0] CPS_BIAS_RESET = 12'h000;
  localparam logic [31:0] CPS_WORD_RESET = 32'h0000_0000;

  // serial mode select codes
  localparam logic [2:0] CPS_MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] CPS_MODE_SLAVE_SERIAL  = 3'h7;

  // dual-purpose pin roles in serial modes (bank 4 = pins 0..2)
  localparam int          CPS_PIN_DIN       = 0;
  localparam int          CPS_PIN_DOUT      = 1;
  localparam int          CPS_PIN_INIT      = 2;
  localparam int          CPS_PIN_D1        = 3;
  localparam logic [11:0] CPS_SERIAL_PINS   = 12'h007;

  // synchroniser bit positions
  localparam int CPS_SY_CFCLK = 0;
  localparam int CPS_SY_DIN   = 1;
  localparam int CPS_SY_TCK   = 2;
  localparam int CPS_SY_TDI   = 3;
  localparam int CPS_SY_TMS   = 4;
  localparam int CPS_SY_PROG  = 5;
  localparam int CPS_SY_HSWAP = 6;
  localparam int CPS_SY_MODE  = 7;
  localparam int CPS_SY_W     = 10;

  localparam logic [4:0] CPS_WORD_LAST = 5'h1F;

endpackage

// *** hdl/cps_config_pins.sv ***
// configuration pin control, serial config capture and test port sampling
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module cps_config_pins
  import cps_pkg::*;
#(
  parameter int NUM_DUAL = 12
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                program_request_n,
  input  wire logic                hot_swap_pullup_disable,
  input  wire logic                mode_select_bit2,
  input  wire logic                mode_select_bit1,
  input  wire logic                mode_select_bit0,
  input  wire logic                config_clock,
  input  wire logic [NUM_DUAL-1:0] dual_in,
  output logic      [NUM_DUAL-1:0] dual_o,
  output logic      [NUM_DUAL-1:0] dual_oe_n,
  output logic      [NUM_DUAL-1:0] dual_pullup,
  output logic      [NUM_DUAL-1:0] dual_pulldown,
  input  wire logic [NUM_DUAL-1:0] user_out,
  input  wire logic [NUM_DUAL-1:0] user_oe_n,
  input  wire logic [NUM_DUAL-1:0] user_unused,
  output logic                     config_pins_pullup,
  output logic                     hot_swap_pullup,
  output logic                     hot_swap_pulldown,
  input  wire logic                tck,
  input  wire logic                tdi,
  input  wire logic                tms,
  output logic                     tdo_o,
  output logic                     tdo_oe_n,
  output logic      [3:0]          test_pullup,
  output logic      [3:0]          test_pulldown,
  output logic                     config_active
);

  function automatic logic bias_up(input logic [1:0] f);
    return f == CPS_BIAS_UP;
  endfunction

  function automatic logic bias_down(input logic [1:0] f);
    return f == CPS_BIAS_DOWN;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [CPS_SY_W-1:0] sync1_r;
  logic [CPS_SY_W-1:0] sync2_r;
  logic [CPS_SY_W-1:0] prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= CPS_SY_W'(32'h0000_0001 << CPS_SY_PROG);
      sync2_r <= CPS_SY_W'(32'h0000_0001 << CPS_SY_PROG);
      prev_r  <= CPS_SY_W'(32'h0000_0001 << CPS_SY_PROG);
    end else begin
      sync1_r <= {mode_select_bit2, mode_select_bit1, mode_select_bit0, hot_swap_pullup_disable,
                  program_request_n, tms, tdi, tck, dual_in[CPS_PIN_DIN], config_clock};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  logic       cfclk_rise;
  logic       tck_rise;
  logic       prog_fall;
  logic       din_s;
  logic       tdi_s;
  logic       tms_s;
  logic       hswap_s;
  logic [2:0] mode_s;
  logic       serial_mode;

  assign cfclk_rise  = sync2_r[CPS_SY_CFCLK] & ~prev_r[CPS_SY_CFCLK];
  assign tck_rise    = sync2_r[CPS_SY_TCK] & ~prev_r[CPS_SY_TCK];
  assign prog_fall   = ~sync2_r[CPS_SY_PROG] & prev_r[CPS_SY_PROG];
  assign din_s       = sync2_r[CPS_SY_DIN];
  assign tdi_s       = sync2_r[CPS_SY_TDI];
  assign tms_s       = sync2_r[CPS_SY_TMS];
  assign hswap_s     = sync2_r[CPS_SY_HSWAP];
  assign mode_s      = sync2_r[CPS_SY_MODE +: 3];
  assign serial_mode = (mode_s == CPS_MODE_MASTER_SERIAL) | (mode_s == CPS_MODE_SLAVE_SERIAL);

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  logic wr_en;
  logic rd_setup;
  logic mapped;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == CPS_OFF_CTRL) | (paddr == CPS_OFF_STATUS) | (paddr == CPS_OFF_BIAS) |
                    (paddr == CPS_OFF_CFG_WORD) | (paddr == CPS_OFF_SCAN_TDI) |
                    (paddr == CPS_OFF_SCAN_TMS) | (paddr == CPS_OFF_SCAN_OUT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  logic ctrl_wr;
  logic status_wr;
  logic done_req;
  logic restart_req;
  logic readback_req;
  assign ctrl_wr      = wr_en & (paddr == CPS_OFF_CTRL);
  assign status_wr    = wr_en & (paddr == CPS_OFF_STATUS);
  assign done_req     = ctrl_wr & pwdata[CPS_CTRL_DONE];
  assign restart_req  = ctrl_wr & pwdata[CPS_CTRL_RESTART];
  assign readback_req = ctrl_wr & pwdata[CPS_CTRL_READBACK];

  logic        keep_pins_r;
  logic [11:0] bias_r;
  logic [31:0] scan_out_r;
  logic        scan_out_wr;
  assign scan_out_wr = wr_en & (paddr == CPS_OFF_SCAN_OUT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_pins_r <= 1'b0;
      bias_r      <= CPS_BIAS_RESET;
    end else begin
      if (ctrl_wr) begin
        keep_pins_r <= pwdata[CPS_CTRL_KEEP];
      end
      if (wr_en && paddr == CPS_OFF_BIAS) begin
        bias_r <= pwdata[11:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration-active flag
  logic cfg_active_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_active_r <= 1'b1;
    end else if (prog_fall || restart_req) begin
      cfg_active_r <= 1'b1;
    end else if (done_req) begin
      cfg_active_r <= 1'b0;
    end
  end
  assign config_active = cfg_active_r;

  ////////////////////////////////////////////////////////////////////////
  // serial configuration capture
  logic [31:0] cfg_shift_r;
  logic [31:0] cfg_word_r;
  logic [4:0]  cfg_cnt_r;
  logic        dout_r;
  logic        word_set;
  logic        shift_en;
  assign shift_en = cfclk_rise & cfg_active_r & serial_mode;
  assign word_set = shift_en & (cfg_cnt_r == CPS_WORD_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_shift_r <= CPS_WORD_RESET;
      cfg_word_r  <= CPS_WORD_RESET;
      cfg_cnt_r   <= '0;
      dout_r      <= 1'b0;
    end else if (shift_en) begin
      cfg_shift_r <= {cfg_shift_r[30:0], din_s};
      dout_r      <= cfg_shift_r[31];
      cfg_cnt_r   <= cfg_cnt_r + 5'h01;
      if (cfg_cnt_r == CPS_WORD_LAST) begin
        cfg_word_r <= {cfg_shift_r[30:0], din_s};
      end
    end else if (prog_fall || restart_req) begin
      cfg_cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over clear
  logic sts_word_r;
  logic sts_refused_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_word_r    <= 1'b0;
      sts_refused_r <= 1'b0;
    end else begin
      if (word_set) begin
        sts_word_r <= 1'b1;
      end else if (status_wr && pwdata[CPS_STS_WORD]) begin
        sts_word_r <= 1'b0;
      end
      if (readback_req && serial_mode) begin
        sts_refused_r <= 1'b1;
      end else if (status_wr && pwdata[CPS_STS_REFUSED]) begin
        sts_refused_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test port sampling on test clock rise
  logic [31:0] scan_tdi_r;
  logic [31:0] scan_tms_r;
  logic [7:0]  scan_cnt_r;
  logic        tdo_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_tdi_r <= '0;
      scan_tms_r <= '0;
      scan_cnt_r <= '0;
    end else if (tck_rise) begin
      scan_tdi_r <= {tdi_s, scan_tdi_r[31:1]};
      scan_tms_r <= {tms_s, scan_tms_r[31:1]};
      scan_cnt_r <= scan_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_out_r <= '0;
      tdo_r      <= 1'b0;
    end else if (scan_out_wr) begin
      scan_out_r <= pwdata;
    end else if (tck_rise) begin
      tdo_r      <= scan_out_r[0];
      scan_out_r <= {1'b0, scan_out_r[31:1]};
    end
  end
  assign tdo_o    = tdo_r;
  assign tdo_oe_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // read data, registered in the setup phase
  logic [31:0] prdata_r;
  logic [31:0] status_word;
  assign status_word = {16'h0000, scan_cnt_r, hswap_s, mode_s, serial_mode,
                        sts_refused_r, sts_word_r, cfg_active_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      case (paddr)
        CPS_OFF_CTRL:     prdata_r <= {30'h0, keep_pins_r, 1'b0};
        CPS_OFF_STATUS:   prdata_r <= status_word;
        CPS_OFF_BIAS:     prdata_r <= {20'h00000, bias_r};
        CPS_OFF_CFG_WORD: prdata_r <= cfg_word_r;
        CPS_OFF_SCAN_TDI: prdata_r <= scan_tdi_r;
        CPS_OFF_SCAN_TMS: prdata_r <= scan_tms_r;
        CPS_OFF_SCAN_OUT: prdata_r <= scan_out_r;
        default:          prdata_r <= '0;
      endcase
    end
  end
  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////
  // dual-purpose pin control
  logic [NUM_DUAL-1:0] borrow;
  logic [NUM_DUAL-1:0] dual_o_nxt;
  logic [NUM_DUAL-1:0] dual_oe_n_nxt;
  logic [NUM_DUAL-1:0] dual_pu_nxt;
  logic [NUM_DUAL-1:0] dual_pd_nxt;
  logic                init_low;
  logic [1:0]          idle_bias;
  assign idle_bias = bias_r[CPS_BIAS_IDLE_LSB +: 2];
  assign init_low  = ~sync2_r[CPS_SY_PROG];
  assign borrow = (serial_mode && (cfg_active_r || keep_pins_r)) ? CPS_SERIAL_PINS[NUM_DUAL-1:0] : '0;

  always_comb begin
    for (int i = 0; i < NUM_DUAL; i++) begin
      dual_o_nxt[i]    = 1'b0;
      dual_oe_n_nxt[i] = 1'b1;
      dual_pu_nxt[i]   = 1'b0;
      dual_pd_nxt[i]   = 1'b0;
      if (borrow[i]) begin
        if (i == CPS_PIN_DOUT) begin
          dual_o_nxt[i]    = dout_r;
          dual_oe_n_nxt[i] = 1'b0;
        end else if (i == CPS_PIN_INIT) begin
          dual_oe_n_nxt[i] = ~init_low;
          dual_pu_nxt[i]   = cfg_active_r;
        end
      end else if (cfg_active_r) begin
        dual_pu_nxt[i] = ~hswap_s;
      end else if (user_unused[i]) begin
        dual_pu_nxt[i] = bias_up(idle_bias);
        dual_pd_nxt[i] = bias_down(idle_bias);
      end else begin
        dual_o_nxt[i]    = user_out[i];
        dual_oe_n_nxt[i] = user_oe_n[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_o        <= '0;
      dual_oe_n     <= '1;
      dual_pullup   <= '0;
      dual_pulldown <= '0;
    end else begin
      dual_o        <= dual_o_nxt;
      dual_oe_n     <= dual_oe_n_nxt;
      dual_pullup   <= dual_pu_nxt;
      dual_pulldown <= dual_pd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dedicated pin bias
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_pins_pullup <= 1'b1;
      hot_swap_pullup    <= 1'b1;
      hot_swap_pulldown  <= 1'b0;
      test_pullup        <= 4'hF;
      test_pulldown      <= 4'h0;
    end else begin
      config_pins_pullup <= cfg_active_r;
      hot_swap_pullup    <= cfg_active_r | bias_up(bias_r[CPS_BIAS_HSWAP_LSB +: 2]);
      hot_swap_pulldown  <= ~cfg_active_r & bias_down(bias_r[CPS_BIAS_HSWAP_LSB +: 2]);
      // order tdo, tms, tdi, tck
      test_pullup <= {4{cfg_active_r}} | {bias_up(bias_r[CPS_BIAS_TDO_LSB +: 2]),
                                          bias_up(bias_r[CPS_BIAS_TMS_LSB +: 2]),
                                          bias_up(bias_r[CPS_BIAS_TDI_LSB +: 2]),
                                          bias_up(bias_r[CPS_BIAS_TCK_LSB +: 2])};
      test_pulldown <= {4{~cfg_active_r}} & {bias_down(bias_r[CPS_BIAS_TDO_LSB +: 2]),
                                             bias_down(bias_r[CPS_BIAS_TMS_LSB +: 2]),
                                             bias_down(bias_r[CPS_BIAS_TDI_LSB +: 2]),
                                             bias_down(bias_r[CPS_BIAS_TCK_LSB +: 2])};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TRISTATE: assert property (cfg_active_r |=> dual_oe_n[CPS_PIN_D1])
    else $error("idle pin driven during configuration");
  AST_PULLUP_ON: assert property (cfg_active_r && !hswap_s |=> dual_pullup[CPS_PIN_D1])
    else $error("pull-up missing with hot-swap input low");
  AST_FLOAT: assert property (cfg_active_r && hswap_s |=> !dual_pullup[CPS_PIN_D1])
    else $error("pull-up present with hot-swap input high");
  AST_CFG_PULLS: assert property (cfg_active_r |=> config_pins_pullup && test_pullup == 4'hF)
    else $error("dedicated pin pull-ups missing during configuration");
  AST_USER_MODE: assert property (!cfg_active_r && !user_unused[CPS_PIN_D1]
                                  |=> !dual_pullup[CPS_PIN_D1] && dual_oe_n[CPS_PIN_D1]
                                      == $past(user_oe_n[CPS_PIN_D1]))
    else $error("user pin not released after configuration");
  AST_SERIAL_SHIFT: assert property (shift_en |=> cfg_shift_r[0] == $past(din_s))
    else $error("serial bit not captured on config clock rise");
  AST_TDI_SAMPLE: assert property (tck_rise |=> scan_tdi_r[31] == $past(tdi_s))
    else $error("tdi not sampled on test clock rise");
  AST_TMS_SAMPLE: assert property (tck_rise |=> scan_tms_r[31] == $past(tms_s))
    else $error("tms not sampled on test clock rise");
  AST_TDO_DRIVE: assert property (tck_rise && !scan_out_wr |=> tdo_o == $past(scan_out_r[0]) && !tdo_oe_n)
    else $error("tdo not driven from shift register");
  AST_READBACK: assert property (readback_req && serial_mode |=> sts_refused_r)
    else $error("readback not refused in serial mode");
  AST_RESTART: assert property (prog_fall |=> cfg_active_r ##1 config_pins_pullup)
    else $error("program request did not restart configuration");

  COV_WORD: cover property (word_set);
  COV_DONE: cover property (cfg_active_r ##1 !cfg_active_r);
  COV_KEEP: cover property (!cfg_active_r && keep_pins_r && serial_mode);
  COV_SCAN: cover property (tck_rise ##[1:20] tck_rise);

endmodule
`default_nettype wire

// *** tb/cps_cfg_source.sv ***
// serial configuration source and boundary-scan tester model
`timescale 1ns/1ns
`default_nettype none
module cps_cfg_source (
  output logic      config_clock,
  output logic      din,
  output logic      tck,
  output logic      tdi,
  output logic      tms,
  input  wire logic tdo
);
  initial begin
    config_clock = 1'b0;
    din          = 1'b1;
    tck          = 1'b0;
    tdi          = 1'b1;
    tms          = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // config clock runs only inside a frame; released data flips so it never looks held
  task automatic send_word(input logic [31:0] w);
    #7;
    for (int i = 31; i >= 0; i--) begin
      din = w[i];
      #80 config_clock = 1'b1;
      #80 config_clock = 1'b0;
    end
    din = ~din;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // tdo taken just before each test clock rise
  task automatic scan(input logic [31:0] di, input logic [31:0] ms, output logic [31:0] got);
    #7;
    for (int i = 0; i < 32; i++) begin
      tdi = di[i];
      tms = ms[i];
      #80 got[i] = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
    end
    tdi = ~tdi;
    tms = ~tms;
  endtask
endmodule
`default_nettype wire

// *** tb/config_pin_and_serial_load_control_test.sv ***
// self-checking bench for the configuration pin and serial load block
`timescale 1ns/1ns
`default_nettype none
module config_pin_and_serial_load_control_test;
  import cps_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        program_request_n, hot_swap_pullup_disable, mode_select_bit2, mode_select_bit1, mode_select_bit0;
  logic        config_clock, din, tck, tdi, tms, tdo_o, tdo_oe_n;
  logic        config_pins_pullup, hot_swap_pullup, hot_swap_pulldown, config_active;
  logic [2:0]  m;
  logic [3:0]  test_pullup, test_pulldown;
  logic [7:0]  paddr;
  logic [11:0] dual_in, dual_o, dual_oe_n, dual_pullup, dual_pulldown, user_out, user_oe_n, user_unused, bias;
  logic [31:0] pwdata, prdata, rd, rs, word, sout, di, ms, got;
  int          err_count, checks;

  assign dual_in = {user_out[11:1], din};

  cps_config_pins dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .program_request_n, .hot_swap_pullup_disable, .mode_select_bit2, .mode_select_bit1, .mode_select_bit0,
    .config_clock, .dual_in, .dual_o, .dual_oe_n, .dual_pullup, .dual_pulldown, .user_out, .user_oe_n,
    .user_unused, .config_pins_pullup, .hot_swap_pullup, .hot_swap_pulldown, .tck, .tdi, .tms, .tdo_o,
    .tdo_oe_n, .test_pullup, .test_pulldown, .config_active
  );

  cps_cfg_source src (.config_clock, .din, .tck, .tdi, .tms, .tdo(tdo_o));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // one bit per test pin, tck in bit 0, set where its bias field equals v
  function automatic logic [3:0] fld_is(input logic [11:0] b, input logic [1:0] v);
    for (int i = 0; i < 4; i++) fld_is[i] = (b[4+2*i +: 2] == v);
  endfunction

  task automatic chk_reg(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("Error register at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("Error pins at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_count++;
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp_v);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, exp_v);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rs = 32'h0000_003A;
    err_count = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    program_request_n = 1'b1;
    hot_swap_pullup_disable = 1'b0;
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} = CPS_MODE_MASTER_SERIAL;
    user_out = 12'h000;
    user_oe_n = 12'hFFF;
    user_unused = 12'h000;
    wait_clk(16);
    chk_pin({config_active, test_pullup}, 5'h1F);
    presetn <= 1'b1;
    rdchk(CPS_OFF_BIAS, {20'h0, CPS_BIAS_RESET});
    rdchk(CPS_OFF_CFG_WORD, CPS_WORD_RESET);
    rdchk(8'h40, 32'h0000_0000);
    chk_reg({31'h0, e}, 32'h1);
    rdchk(CPS_OFF_STATUS, 32'h0000_0009);
    // user side asks to drive while configuring
    for (int h = 0; h < 2; h++) begin
      hot_swap_pullup_disable <= h[0];
      user_oe_n <= 12'h000;
      wait_clk(8);
      chk_pin(dual_oe_n[11:3], 9'h1FF);
      chk_pin(dual_pullup[11:3], h ? 9'h000 : 9'h1FF);
      chk_pin({config_pins_pullup, test_pullup}, 5'h1F);
      apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
      chk_reg(rd & 32'h80, {24'h0, h[0], 7'h00});
    end
    for (int k = 0; k < 2; k++) begin
      m = k ? CPS_MODE_SLAVE_SERIAL : CPS_MODE_MASTER_SERIAL;
      {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= m;
      word = k ? nxt() : 32'h8000_0001;
      wait_clk(8);
      src.send_word(word);
      wait_clk(8);
      chk_pin({dual_o[CPS_PIN_DOUT], dual_oe_n[CPS_PIN_DOUT]}, {k == 1, 1'b0});
      apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
      chk_reg(rd & 32'h7F, {25'h0, m, 4'hB});
      rdchk(CPS_OFF_CFG_WORD, word);
      apb(1'b1, CPS_OFF_STATUS, 32'h0000_0002);
      apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
      chk_reg(rd & 32'h2, 32'h0);
    end
    apb(1'b1, CPS_OFF_CTRL, 32'h0000_0008);
    apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
    chk_reg(rd & 32'h4, 32'h4);
    apb(1'b1, CPS_OFF_STATUS, 32'h0000_0004);
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= 3'h3;
    wait_clk(8);
    src.send_word(nxt());
    apb(1'b1, CPS_OFF_CTRL, 32'h0000_0008);
    apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
    chk_reg(rd & 32'h7E, 32'h0000_0030);
    rdchk(CPS_OFF_CFG_WORD, word);
    chk_pin(dual_oe_n[CPS_PIN_DOUT], 1'b1);
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= CPS_MODE_SLAVE_SERIAL;
    for (int k = 0; k < 2; k++) begin
      sout = nxt();
      di = k ? nxt() : 32'hFFFF_0000;
      ms = nxt();
      apb(1'b1, CPS_OFF_SCAN_OUT, sout);
      src.scan(di, ms, got);
      wait_clk(8);
      chk_pin({tdo_oe_n, got[31:1]}, {1'b0, sout[30:0]});
      rdchk(CPS_OFF_SCAN_TDI, di);
      rdchk(CPS_OFF_SCAN_TMS, ms);
      apb(1'b0, CPS_OFF_STATUS, 32'h0000_0000);
      chk_reg({24'h0, rd[15:8]}, 32'h20 * (k + 1));
    end
    word = nxt();
    for (int i = 0; i < 6; i++) bias[2*i +: 2] = (word[2*i +: 2] == 2'h3) ? 2'h0 : word[2*i +: 2];
    apb(1'b1, CPS_OFF_BIAS, {20'h0, bias});
    rdchk(CPS_OFF_BIAS, {20'h0, bias});
    chk_pin(test_pullup, 4'hF);
    word = nxt();
    user_unused <= 12'hF00;
    user_out <= word[11:0];
    user_oe_n <= word[23:12] & 12'hFFE;
    apb(1'b1, CPS_OFF_CTRL, 32'h0000_0003);
    wait_clk(8);
    chk_pin(config_active, 1'b0);
    chk_pin({test_pullup, test_pulldown}, {fld_is(bias, CPS_BIAS_UP), fld_is(bias, CPS_BIAS_DOWN)});
    chk_pin({hot_swap_pullup, hot_swap_pulldown}, {bias[3:2] == CPS_BIAS_UP, bias[3:2] == CPS_BIAS_DOWN});
    chk_pin({dual_pullup[11:8], dual_pulldown[11:8], dual_oe_n[11:8]},
            {{4{bias[1:0] == CPS_BIAS_UP}}, {4{bias[1:0] == CPS_BIAS_DOWN}}, 4'hF});
    chk_pin({dual_o[7:3], dual_oe_n[7:3]}, {user_out[7:3], user_oe_n[7:3]});
    chk_pin(dual_oe_n[0], 1'b1);
    hot_swap_pullup_disable <= 1'b0;
    wait_clk(8);
    chk_pin(dual_pullup[7:3], 5'h00);
    program_request_n <= 1'b0;
    wait_clk(8);
    chk_pin({config_active, dual_oe_n[7:2]}, 7'h7E);
    program_request_n <= 1'b1;
    wait_clk(8);
    apb(1'b1, CPS_OFF_CTRL, 32'h0000_0001);
    wait_clk(8);
    chk_pin({dual_o[2:0], dual_oe_n[2:0]}, {user_out[2:0], user_oe_n[2:0]});
    tally_and_finish();
  end
endmodule
`default_nettype wire
